// File: rtl/reset_combiner_cfg.svh
`ifndef RESET_COMBINER_CFG_SVH
`define RESET_COMBINER_CFG_SVH
// ****************************************
// register map
// ****************************************
`define RCS_ADDR_W 4
`define RCS_OFFSET 4'h0
`define RCS_RESET_VALUE 16'h0003
`define RCS_POR_ONLY 16'h0001
`define RCS_IMPL_MASK 16'hC3FF
// ****************************************
// field positions
// ****************************************
`define RCS_TRAP_BIT 15
`define RCS_ILLEGAL_BIT 14
`define RCS_CM_BIT 9
`define RCS_VREG_BIT 8
`define RCS_PIN_BIT 7
`define RCS_INSTR_BIT 6
`define RCS_SWDT_BIT 5
`define RCS_WATCHDOG_TIMEOUT_FLAG_BIT 4
`define RCS_SLEEP_BIT 3
`define RCS_IDLE_BIT 2
`define RCS_BOR_BIT 1
`define RCS_POR_BIT 0
// ****************************************
// bus responses
// ****************************************
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_DECERR 2'h3
`endif

// File: rtl/reset_combiner_pkg.sv
package reset_combiner_pkg;
	typedef logic [15:0] status_t;
	typedef logic [3:0] addr_t;
endpackage : reset_combiner_pkg

// File: rtl/reset_source_combiner_status.sv
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "reset_combiner_cfg.svh"
module reset_source_combiner_status (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_por_event,
	input wire logic i_brownout_event,
	input wire logic i_external_reset_pin_n,
	input wire logic i_reset_instr,
	input wire logic i_watchdog_timeout,
	input wire logic i_config_mismatch,
	input wire logic i_trap_conflict,
	input wire logic i_illegal_condition,
	input wire logic i_in_sleep,
	input wire logic i_in_idle,
	input wire logic i_watchdog_fuse_enable,
	input wire logic [3:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [3:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic o_master_system_reset,
	output logic o_watchdog_enable,
	output logic o_regulator_sleep_active,
	output logic o_watchdog_wake
);
	// ****************************************
	// pin synchroniser
	// ****************************************
	logic pin_meta_q;
	logic pin_sync_q;
	// two stages before any logic reads the pin
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
		end else begin
			pin_meta_q <= i_external_reset_pin_n;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ****************************************
	// reset combining and cause flags
	// ****************************************
	reset_combiner_pkg::status_t status_d;
	reset_combiner_pkg::status_t status_q;
	logic master_system_reset_d;
	logic master_system_reset_q;
	logic wdt_en_d;
	logic wdt_en_q;
	logic wake_d;
	logic wake_q;
	logic wdt_reset;
	logic low_power;
	logic sw_wr;
	reset_combiner_pkg::status_t sw_mask;
	reset_combiner_pkg::status_t hw_set;

	// bus write strobe into the status register
	logic wr_fire;
	reset_combiner_pkg::addr_t wr_addr_q;
	logic [31:0] wr_data_q;
	logic [3:0] wr_strb_q;

	// next status, reset level and watchdog enable
	always_comb begin
		low_power = i_in_sleep | i_in_idle;
		wdt_reset = i_watchdog_timeout & ~low_power;
		sw_wr = wr_fire && (wr_addr_q == `RCS_OFFSET);
		sw_mask = {{8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
		hw_set = '0;
		hw_set[`RCS_TRAP_BIT] = i_trap_conflict;
		hw_set[`RCS_ILLEGAL_BIT] = i_illegal_condition;
		hw_set[`RCS_CM_BIT] = i_config_mismatch;
		hw_set[`RCS_PIN_BIT] = ~pin_sync_q;
		hw_set[`RCS_INSTR_BIT] = i_reset_instr;
		hw_set[`RCS_WATCHDOG_TIMEOUT_FLAG_BIT] = i_watchdog_timeout;
		hw_set[`RCS_SLEEP_BIT] = i_in_sleep;
		hw_set[`RCS_IDLE_BIT] = i_in_idle;
		hw_set[`RCS_BOR_BIT] = i_brownout_event;
		hw_set[`RCS_POR_BIT] = i_por_event;
		status_d = status_q;
		if (sw_wr) begin
			status_d = (status_q & ~sw_mask) | (wr_data_q[15:0] & sw_mask);
		end
		// hardware set wins over a simultaneous software clear
		status_d = (status_d | hw_set) & `RCS_IMPL_MASK;
		if (i_por_event) begin
			status_d = `RCS_POR_ONLY;
		end
		// any active source drives master reset, watchdog timeout only outside sleep and idle; flags play no part
		master_system_reset_d = i_por_event | i_brownout_event | ~pin_sync_q | i_reset_instr | wdt_reset
			| i_config_mismatch | i_trap_conflict | i_illegal_condition;
		wdt_en_d = i_watchdog_fuse_enable | status_d[`RCS_SWDT_BIT];
		wake_d = i_watchdog_timeout & low_power;
	end

	// status and reset registers
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			status_q <= `RCS_RESET_VALUE;
			master_system_reset_q <= 1'b1;
			wdt_en_q <= 1'b1;
			wake_q <= 1'b0;
		end else begin
			status_q <= status_d;
			master_system_reset_q <= master_system_reset_d;
			wdt_en_q <= wdt_en_d;
			wake_q <= wake_d;
		end
	end

	assign o_master_system_reset = master_system_reset_q;
	assign o_watchdog_enable = wdt_en_q;
	assign o_regulator_sleep_active = status_q[`RCS_VREG_BIT];
	assign o_watchdog_wake = wake_q;

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_have_d;
	logic aw_have_q;
	logic w_have_d;
	logic w_have_q;
	logic awready_d;
	logic awready_q;
	logic wready_d;
	logic wready_q;
	logic bvalid_d;
	logic bvalid_q;
	logic [1:0] bresp_d;
	logic [1:0] bresp_q;
	reset_combiner_pkg::addr_t wr_addr_d;
	logic [31:0] wr_data_d;
	logic [3:0] wr_strb_d;
	logic arready_d;
	logic arready_q;
	logic rvalid_d;
	logic rvalid_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_d;
	logic [1:0] rresp_q;

	// write and read channel sequencing
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		wr_strb_d = wr_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		wr_fire = 1'b0;
		if (i_s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			wr_addr_d = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wr_data_d = i_s_axi_wdata;
			wr_strb_d = i_s_axi_wstrb;
		end
		if (bvalid_q && i_s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// commit once both halves are held
		if (aw_have_q && w_have_q && !bvalid_q) begin
			wr_fire = 1'b1;
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (wr_addr_q == `RCS_OFFSET) ? `AXI_RESP_OKAY : `AXI_RESP_DECERR;
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d = !w_have_d && !bvalid_d;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && i_s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (i_s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			if (i_s_axi_araddr == `RCS_OFFSET) begin
				rdata_d = {16'h0000, status_q};
				rresp_d = `AXI_RESP_OKAY;
			end else begin
				rdata_d = 32'h00000000;
				rresp_d = `AXI_RESP_DECERR;
			end
		end
		arready_d = !rvalid_d;
	end

	// bus registers
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			wr_addr_q <= 4'h0;
			wr_data_q <= 32'h00000000;
			wr_strb_q <= 4'h0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
			wr_strb_q <= wr_strb_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign o_s_axi_awready = awready_q;
	assign o_s_axi_wready = wready_q;
	assign o_s_axi_bvalid = bvalid_q;
	assign o_s_axi_bresp = bresp_q;
	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid = rvalid_q;
	assign o_s_axi_rdata = rdata_q;
	assign o_s_axi_rresp = rresp_q;

	// ****************************************
	// assertions
	// ****************************************
	sequence trap_seen_s;
		i_trap_conflict && !i_por_event;
	endsequence

	sequence trap_flag_s;
		status_q[`RCS_TRAP_BIT] && o_master_system_reset;
	endsequence

	trap_flag_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		trap_seen_s |=> trap_flag_s)
		else $error("trap conflict did not set flag and reset");

	source_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_config_mismatch || i_illegal_condition || i_brownout_event) |=> o_master_system_reset)
		else $error("active source without master reset");

	quiet_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!i_por_event && !i_brownout_event && pin_sync_q && !i_reset_instr && !i_watchdog_timeout
		&& !i_config_mismatch && !i_trap_conflict && !i_illegal_condition) |=> !o_master_system_reset)
		else $error("master reset without any source");

	por_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_por_event |=> (status_q == `RCS_POR_ONLY))
		else $error("power-on event left other flags set");

	instr_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_reset_instr && !i_por_event) ##1 (!i_reset_instr && !i_por_event && !i_brownout_event && pin_sync_q
		&& !i_watchdog_timeout && !i_config_mismatch && !i_trap_conflict && !i_illegal_condition && !wr_fire)
		|=> !o_master_system_reset && status_q[`RCS_INSTR_BIT])
		else $error("instruction reset not one cycle or flag lost");

	wdt_sleep_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_watchdog_timeout && (i_in_sleep || i_in_idle) && !i_por_event)
		|=> o_watchdog_wake && status_q[`RCS_WATCHDOG_TIMEOUT_FLAG_BIT])
		else $error("watchdog timeout in low power did not wake");

	fuse_enable_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_watchdog_fuse_enable |=> o_watchdog_enable)
		else $error("fuse high but watchdog disabled");

	unimpl_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_s_axi_rvalid |-> (o_s_axi_rdata[13:10] == 4'h0) && (o_s_axi_rdata[31:16] == 16'h0000))
		else $error("unimplemented bits read nonzero");

	flag_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(status_q[`RCS_CM_BIT] && !i_por_event && !wr_fire) |=> status_q[`RCS_CM_BIT])
		else $error("mismatch flag dropped without clear");

	pin_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		($fell(i_external_reset_pin_n) && !i_por_event) ##1 !i_por_event ##1 !i_por_event
		|=> status_q[`RCS_PIN_BIT] && o_master_system_reset)
		else $error("pin reset not flagged within three cycles");

	regulator_out_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(sw_wr && wr_strb_q[1] && !i_por_event) |=> (o_regulator_sleep_active == $past(wr_data_q[`RCS_VREG_BIT])))
		else $error("regulator output not following written bit 8");
endmodule : reset_source_combiner_status
`default_nettype wire

// File: testbench/reset_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_fire,
	input wire logic [2:0] i_sel,
	output logic [7:0] o_src,
	output logic o_pin_n
);
	logic [7:0] src_q;
	logic [7:0] src_d;
	// one request becomes a one-cycle pulse on the chosen source
	always_comb begin
		src_d = i_fire ? (8'h01 << i_sel) : 8'h00;
	end
	// source pulse register
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			src_q <= 8'h00;
		end else begin
			src_q <= src_d;
		end
	end
	assign o_src = src_q;
	assign o_pin_n = ~src_q[2]; // pin idles high, pulls low to reset
endmodule : reset_source_model
`default_nettype wire

// File: testbench/reset_source_combiner_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_combiner_cfg.svh"
module reset_source_combiner_status_bench;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic fire = 1'h0;
	logic [2:0] sel = 3'h0;
	logic sleep = 1'h0;
	logic idle = 1'h0;
	logic fuse = 1'h0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [7:0] src;
	logic pin_n, awready, wready, bvalid, arready, rvalid, msr, wde, reg_act, wake;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int nr, nw;
	int pos [8] = '{0, `RCS_BOR_BIT, `RCS_PIN_BIT, `RCS_INSTR_BIT, `RCS_WATCHDOG_TIMEOUT_FLAG_BIT, `RCS_CM_BIT, `RCS_TRAP_BIT,
		`RCS_ILLEGAL_BIT};
	reset_source_model u_src (.i_ref_clk(clk), .i_rst(rst), .i_fire(fire), .i_sel(sel), .o_src(src),
		.o_pin_n(pin_n));
	reset_source_combiner_status u_dut (.i_ref_clk(clk), .i_rst(rst), .i_por_event(src[0]),
		.i_brownout_event(src[1]), .i_external_reset_pin_n(pin_n), .i_reset_instr(src[3]),
		.i_watchdog_timeout(src[4]), .i_config_mismatch(src[5]), .i_trap_conflict(src[6]),
		.i_illegal_condition(src[7]), .i_in_sleep(sleep), .i_in_idle(idle), .i_watchdog_fuse_enable(fuse),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .o_master_system_reset(msr), .o_watchdog_enable(wde),
		.o_regulator_sleep_active(reg_act), .o_watchdog_wake(wake));
	// ****************
	// clock and hang guard
	// ****************
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			give_verdict();
		end
	end
	// ****************
	// shared tasks
	// ****************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		rsp = bresp;
		bready <= 1'h0;
	endtask : wr
	task rd_reg(input logic [3:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'h0;
	endtask : rd_reg
	// pulse one source, then count reset and wake cycles
	task fire_watch(input logic [2:0] s);
		@(posedge clk);
		fire <= 1'h1;
		sel <= s;
		@(posedge clk);
		fire <= 1'h0;
		nr = 0;
		nw = 0;
		repeat (8) begin
			@(posedge clk);
			nr += (msr !== 1'h0);
			nw += (wake !== 1'h0);
		end
	endtask : fire_watch
	task give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		rd_reg(4'h0);
		chk(rd, `RCS_RESET_VALUE);
		chk(msr, 1'h0);
		wr(4'h0, 32'h0);
		chk(rsp, `AXI_RESP_OKAY);
		rd_reg(4'h0);
		chk(rd, 32'h0);
		for (int i = 1; i < 8; i++) begin
			fire_watch(3'(i));
			chk(nr, 1);
			rd_reg(4'h0);
			chk(rd, 32'h1 << pos[i]);
			wr(4'h0, 32'h0);
		end
		wr(4'h0, 32'hFFFF);
		repeat (6) @(posedge clk);
		chk(msr, 1'h0);
		chk(wde, 1'h1);
		chk(reg_act, 1'h1);
		rd_reg(4'h0);
		chk(rd, `RCS_IMPL_MASK);
		fire_watch(3'h0);
		chk(nr, 1);
		rd_reg(4'h0);
		chk(rd, `RCS_POR_ONLY);
		chk(wde, 1'h0);
		chk(reg_act, 1'h0);
		fuse <= 1'h1;
		repeat (3) @(posedge clk);
		chk(wde, 1'h1);
		fuse <= 1'h0;
		wr(4'h0, 32'h0);
		for (int j = 0; j < 2; j++) begin
			sleep <= (j == 0);
			idle <= (j == 1);
			fire_watch(3'h4);
			chk(nr, 0);
			chk(nw, 1);
			sleep <= 1'h0;
			idle <= 1'h0;
			rd_reg(4'h0);
			chk(rd, (j == 0) ? 32'h18 : 32'h14);
			wr(4'h0, 32'h0);
		end
		wr(4'h4, 32'hFFFF);
		chk(rsp, `AXI_RESP_DECERR);
		rd_reg(4'h4);
		chk(rd, 32'h0);
		chk(rsp, `AXI_RESP_DECERR);
		rd_reg(4'h0);
		chk(rd, 32'h0);
		chk(rsp, `AXI_RESP_OKAY);
		give_verdict();
	end
endmodule : reset_source_combiner_status_bench
`default_nettype wire
